// >>> verilog/cadec_pkg.sv
`default_nettype none
package cadec_pkg;

   // opcode and operand-specifier patterns
   localparam logic [5:0] OPC_ADC_RM  = 6'h04;
   localparam logic [5:0] OPC_IMM_GRP = 6'h20;
   localparam logic [6:0] OPC_ADC_ACC = 7'h0A;
   localparam logic [6:0] OPC_INC_RM  = 7'h7F;
   localparam logic [2:0] EXT_ADC     = 3'h2;
   localparam logic [2:0] EXT_INC     = 3'h0;
   localparam logic [1:0] MOD_NODISP  = 2'h0;
   localparam logic [1:0] MOD_D8      = 2'h1;
   localparam logic [1:0] MOD_D32     = 2'h2;
   localparam logic [1:0] MOD_REG     = 2'h3;
   localparam logic [2:0] RM_SIB      = 3'h4;
   localparam logic [2:0] RM_D32      = 3'h5;

   // execution clocks and data-cycle figures
   localparam logic [3:0] CLK_ONE     = 4'h1;
   localparam logic [3:0] CLK_RR      = 4'h2;
   localparam logic [3:0] CLK_RM      = 4'h7;
   localparam logic [3:0] CLK_MR      = 4'h6;
   localparam logic [3:0] CLK_IMM_R   = 4'h2;
   localparam logic [3:0] CLK_IMM_M   = 4'h7;
   localparam logic [3:0] CLK_ACC     = 4'h2;
   localparam logic [3:0] CLK_INC_R   = 4'h2;
   localparam logic [3:0] CLK_INC_M   = 4'h6;
   localparam logic [1:0] DC_ZERO     = 2'h0;
   localparam logic [1:0] DC_ONE      = 2'h1;
   localparam logic [1:0] DC_TWO      = 2'h2;

   // byte counts of trailing fields
   localparam logic [2:0] LEN_NONE    = 3'h0;
   localparam logic [2:0] LEN_B8      = 3'h1;
   localparam logic [2:0] LEN_B32     = 3'h4;

   typedef enum logic [2:0] {
      CADEC_K_NONE, CADEC_K_ADC_RR, CADEC_K_ADC_RM, CADEC_K_ADC_MR,
      CADEC_K_ADC_IMM, CADEC_K_ADC_ACC, CADEC_K_INC
   } cadec_kind_t;

   typedef enum logic [2:0] {
      CADEC_S_OPC, CADEC_S_MODRM, CADEC_S_SIB, CADEC_S_DISP, CADEC_S_IMM, CADEC_S_EXEC
   } cadec_state_t;

   typedef struct packed {
      logic [5:0] top;
      logic       dir;
      logic       wide;
   } cadec_opc_t;

   typedef struct packed {
      logic [1:0] mode;
      logic [2:0] reg_f;
      logic [2:0] rm;
   } cadec_modrm_t;

   typedef struct packed {
      logic [1:0] scale;
      logic [2:0] index;
      logic [2:0] base;
   } cadec_sib_t;

   typedef struct packed {
      cadec_kind_t  kind;
      logic         wide;
      logic         dir;
      logic         sext;
      logic         is_mem;
      cadec_modrm_t modrm;
      cadec_sib_t   sib;
      logic [31:0]  disp;
      logic [31:0]  imm;
      logic [3:0]   clocks;
      logic [1:0]   data_cycles;
   } cadec_op_t;

   typedef struct packed {
      cadec_state_t st;
      cadec_opc_t   opc;
      cadec_op_t    op;
      logic [2:0]   cnt;
      logic [3:0]   exec;
      logic         op_valid;
      logic         bad_opcode;
   } cadec_regs_t;

   function automatic logic [2:0] cadec_disp_len(input cadec_op_t op);
      logic [2:0] len;
      len = LEN_NONE;
      if (op.is_mem) begin
         if (op.modrm.mode == MOD_D8) begin
            len = LEN_B8;
         end else if (op.modrm.mode == MOD_D32) begin
            len = LEN_B32;
         end else if (op.modrm.rm == RM_D32) begin
            len = LEN_B32;
         end else if (op.modrm.rm == RM_SIB && op.sib.base == RM_D32) begin
            len = LEN_B32;
         end
      end
      return len;
   endfunction : cadec_disp_len

   function automatic logic [2:0] cadec_imm_len(input cadec_op_t op);
      logic [2:0] len;
      len = LEN_NONE;
      if (op.kind == CADEC_K_ADC_IMM || op.kind == CADEC_K_ADC_ACC) begin
         len = (!op.wide || op.sext) ? LEN_B8 : LEN_B32;
      end
      return len;
   endfunction : cadec_imm_len

endpackage : cadec_pkg
`default_nettype wire

// >>> verilog/cadec_decode.sv
// Function
// [RQ1] Opcode 000100dw with a register-mode operand byte decodes as register-to-register add with carry in 2 clocks.
// [RQ2] Opcode 0001000w with a memory operand byte decodes as add with carry into memory, 7 clocks, 2 data cycles.
// [RQ3] Opcode 0001001w with a memory operand byte decodes as add with carry into a register, 6 clocks, 1 data cycle.
// [RQ4] Opcode 100000sw with middle field 010 adds an immediate with carry, 2 clocks to a register or 7 to memory.
// [RQ5] Opcode 0001010w followed by immediate data adds it with carry to the accumulator in 2 clocks.
// [RQ6] Opcode 1111111w with middle field 000 increments, 2 clocks and 0 data cycles for a register, 6 and 2 for memory.
// [RQ7] Direction, width, sign and mode/register/memory fields keep their customary meanings.
`timescale 1ns/1ns
`default_nettype none
module cadec_decode (
   input  wire logic                 sys_clk,
   input  wire logic                 arst_n,
   input  wire logic                 byte_valid,
   input  wire logic [7:0]           byte_data,
   output logic                      byte_ready,
   output logic                      op_valid,
   output cadec_pkg::cadec_op_t      op,
   output logic                      bad_opcode
);
   import cadec_pkg::*;

   cadec_regs_t  cur_ff;
   cadec_regs_t  nxt_regs;
   logic         take;
   cadec_opc_t   opc_in;
   cadec_modrm_t modrm_in;
   logic         mem;
   logic         ok;
   logic [2:0]   dlen;
   logic [2:0]   ilen;

   // picks the first trailing field still owed after the current byte
   function automatic cadec_state_t tail_state(input logic need_sib, input logic [2:0] d_len,
                                               input logic [2:0] i_len);
      cadec_state_t s;
      if (need_sib) begin
         s = CADEC_S_SIB;
      end else if (d_len != LEN_NONE) begin
         s = CADEC_S_DISP;
      end else if (i_len != LEN_NONE) begin
         s = CADEC_S_IMM;
      end else begin
         s = CADEC_S_EXEC;
      end
      return s;
   endfunction : tail_state

   // the queue is stalled for the whole execution time so timing stays exact
   assign byte_ready = (cur_ff.st != CADEC_S_EXEC);
   assign take       = byte_valid && byte_ready;
   assign opc_in     = cadec_opc_t'(byte_data);
   assign modrm_in   = cadec_modrm_t'(byte_data);
   assign op_valid   = cur_ff.op_valid;
   assign op         = cur_ff.op;
   assign bad_opcode = cur_ff.bad_opcode;

   always_comb begin
      nxt_regs            = cur_ff;
      nxt_regs.op_valid   = 1'b0;
      nxt_regs.bad_opcode = 1'b0;
      mem                 = (modrm_in.mode != MOD_REG);
      ok                  = 1'b1;
      dlen                = LEN_NONE;
      ilen                = LEN_NONE;
      unique case (cur_ff.st)
         CADEC_S_OPC: begin
            if (take) begin
               nxt_regs.op      = '0;
               nxt_regs.cnt     = LEN_NONE;
               nxt_regs.opc     = opc_in;
               nxt_regs.op.wide = opc_in.wide; // RQ7
               nxt_regs.op.dir  = opc_in.dir; // RQ7
               if (opc_in.top == OPC_ADC_RM || opc_in.top == OPC_IMM_GRP
                   || {opc_in.top, opc_in.dir} == OPC_INC_RM) begin
                  nxt_regs.st = CADEC_S_MODRM;
               end else if ({opc_in.top, opc_in.dir} == OPC_ADC_ACC) begin
                  nxt_regs.op.kind        = CADEC_K_ADC_ACC; // RQ5
                  nxt_regs.op.dir         = 1'b0;
                  nxt_regs.op.clocks      = CLK_ACC; // RQ5
                  nxt_regs.op.data_cycles = DC_ZERO;
                  nxt_regs.st             = CADEC_S_IMM;
               end else begin
                  nxt_regs.bad_opcode = 1'b1;
               end
            end
         end
         CADEC_S_MODRM: begin
            if (take) begin
               nxt_regs.op.modrm  = modrm_in;
               nxt_regs.op.is_mem = mem; // RQ7
               if (cur_ff.opc.top == OPC_ADC_RM) begin
                  if (!mem) begin
                     nxt_regs.op.kind        = CADEC_K_ADC_RR; // RQ1
                     nxt_regs.op.clocks      = CLK_RR; // RQ1
                     nxt_regs.op.data_cycles = DC_ZERO;
                  end else if (!cur_ff.opc.dir) begin
                     nxt_regs.op.kind        = CADEC_K_ADC_RM; // RQ2
                     nxt_regs.op.clocks      = CLK_RM; // RQ2
                     nxt_regs.op.data_cycles = DC_TWO; // RQ2
                  end else begin
                     nxt_regs.op.kind        = CADEC_K_ADC_MR; // RQ3
                     nxt_regs.op.clocks      = CLK_MR; // RQ3
                     nxt_regs.op.data_cycles = DC_ONE; // RQ3
                  end
               end else if (cur_ff.opc.top == OPC_IMM_GRP) begin
                  ok                      = (modrm_in.reg_f == EXT_ADC); // RQ4
                  nxt_regs.op.kind        = CADEC_K_ADC_IMM;
                  nxt_regs.op.sext        = cur_ff.opc.dir && cur_ff.opc.wide; // RQ7
                  nxt_regs.op.dir         = 1'b0;
                  nxt_regs.op.clocks      = mem ? CLK_IMM_M : CLK_IMM_R; // RQ4
                  nxt_regs.op.data_cycles = mem ? DC_TWO : DC_ZERO; // RQ4
               end else begin
                  ok                      = (modrm_in.reg_f == EXT_INC); // RQ6
                  nxt_regs.op.kind        = CADEC_K_INC;
                  nxt_regs.op.dir         = 1'b0;
                  nxt_regs.op.clocks      = mem ? CLK_INC_M : CLK_INC_R; // RQ6
                  nxt_regs.op.data_cycles = mem ? DC_TWO : DC_ZERO; // RQ6
               end
               dlen = cadec_disp_len(nxt_regs.op);
               ilen = cadec_imm_len(nxt_regs.op);
               if (!ok) begin
                  nxt_regs.bad_opcode = 1'b1;
                  nxt_regs.st         = CADEC_S_OPC;
               end else begin
                  nxt_regs.st = tail_state(mem && modrm_in.rm == RM_SIB, dlen, ilen); // RQ7
               end
            end
         end
         CADEC_S_SIB: begin
            if (take) begin
               nxt_regs.op.sib = cadec_sib_t'(byte_data);
               dlen            = cadec_disp_len(nxt_regs.op);
               ilen            = cadec_imm_len(nxt_regs.op);
               nxt_regs.st     = tail_state(1'b0, dlen, ilen);
            end
         end
         CADEC_S_DISP: begin
            dlen = cadec_disp_len(cur_ff.op);
            ilen = cadec_imm_len(cur_ff.op);
            if (take) begin
               // little-endian: byte n lands in lane n
               nxt_regs.op.disp[{cur_ff.cnt[1:0], 3'h0} +: 8] = byte_data;
               nxt_regs.cnt = cur_ff.cnt + LEN_B8;
               if (nxt_regs.cnt == dlen) begin
                  nxt_regs.cnt = LEN_NONE;
                  if (dlen == LEN_B8) begin
                     nxt_regs.op.disp = {{24{byte_data[7]}}, byte_data};
                  end
                  nxt_regs.st = tail_state(1'b0, LEN_NONE, ilen);
               end
            end
         end
         CADEC_S_IMM: begin
            ilen = cadec_imm_len(cur_ff.op);
            if (take) begin
               nxt_regs.op.imm[{cur_ff.cnt[1:0], 3'h0} +: 8] = byte_data; // RQ4 RQ5
               nxt_regs.cnt = cur_ff.cnt + LEN_B8;
               if (nxt_regs.cnt == ilen) begin
                  nxt_regs.cnt = LEN_NONE;
                  if (cur_ff.op.sext) begin
                     nxt_regs.op.imm = {{24{byte_data[7]}}, byte_data}; // RQ7
                  end
                  nxt_regs.st = CADEC_S_EXEC;
               end
            end
         end
         CADEC_S_EXEC: begin
            if (cur_ff.exec == 4'h0) begin
               nxt_regs.st = CADEC_S_OPC;
            end else begin
               nxt_regs.exec = cur_ff.exec - CLK_ONE;
            end
         end
      endcase
      // issue: the op is shown for one cycle and execution holds for its clock count
      if (nxt_regs.st == CADEC_S_EXEC && cur_ff.st != CADEC_S_EXEC) begin
         nxt_regs.op_valid = 1'b1;
         nxt_regs.exec     = nxt_regs.op.clocks - CLK_ONE; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_regs;
      end
   end

   chk_rr_timing: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ1
      op_valid && op.kind == CADEC_K_ADC_RR |-> op.clocks == CLK_RR && !op.is_mem
      && (!byte_ready)[*2] ##1 byte_ready)
      else $error("reg-reg add with carry timing wrong");

   chk_rm_timing: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ2
      op_valid && op.kind == CADEC_K_ADC_RM |-> op.data_cycles == DC_TWO && !op.dir
      && (!byte_ready)[*7] ##1 byte_ready)
      else $error("reg-to-mem add with carry timing wrong");

   chk_mr_timing: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ3
      op_valid && op.kind == CADEC_K_ADC_MR |-> op.data_cycles == DC_ONE && op.dir
      && (!byte_ready)[*6] ##1 byte_ready)
      else $error("mem-to-reg add with carry timing wrong");

   chk_imm_form: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ4
      op_valid && op.kind == CADEC_K_ADC_IMM |-> op.modrm.reg_f == EXT_ADC
      && op.clocks == (op.is_mem ? CLK_IMM_M : CLK_IMM_R))
      else $error("immediate add with carry decode wrong");

   chk_acc_form: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ5
      op_valid && op.kind == CADEC_K_ADC_ACC |-> op.clocks == CLK_ACC
      && $past(cur_ff.st) == CADEC_S_IMM)
      else $error("accumulator add with carry decode wrong");

   chk_inc_form: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ6
      op_valid && op.kind == CADEC_K_INC |-> op.modrm.reg_f == EXT_INC
      && op.data_cycles == (op.is_mem ? DC_TWO : DC_ZERO)
      && op.clocks == (op.is_mem ? CLK_INC_M : CLK_INC_R))
      else $error("increment decode wrong");

   chk_sign_extend: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ7
      op_valid && op.sext |-> op.imm[31:8] == {24{op.imm[7]}} && op.wide)
      else $error("sign extension of immediate wrong");

   chk_mode_mem: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ7
      op_valid |-> op.is_mem == (op.kind != CADEC_K_ADC_ACC && op.modrm.mode != MOD_REG))
      else $error("memory operand flag disagrees with mode");

endmodule : cadec_decode
`default_nettype wire

// >>> tb/cadec_fetch_model.sv
`timescale 1ns/1ns
`default_nettype none
// prefetch queue stand-in: offers queued bytes, holds each until taken
module cadec_fetch_model (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       byte_ready,
   input  wire logic       slow,
   output logic            byte_valid,
   output logic [7:0]      byte_data
);
   logic [7:0] q[$];
   logic       taken;
   logic       gap;

   task automatic push(input logic [63:0] seq, input int n);
      for (int i = 0; i < n; i++) begin
         q.push_back(seq[8*i +: 8]);
      end
   endtask : push

   initial begin
      byte_valid = 1'b0;
      byte_data  = 8'h00;
      taken      = 1'b0;
      gap        = 1'b0;
   end

   always @(posedge sys_clk) begin
      taken <= byte_valid && byte_ready && arst_n;
   end

   // idle data toggles every cycle so a stale byte can never look valid
   always @(negedge sys_clk) begin
      if (taken) begin
         q.delete(0);
      end
      gap = taken && slow;
      if (q.size() == 0 || gap || !arst_n) begin
         byte_valid = 1'b0;
         byte_data  = ~byte_data;
      end else begin
         byte_valid = 1'b1;
         byte_data  = q[0];
      end
   end
endmodule : cadec_fetch_model
`default_nettype wire

// >>> tb/test_carry_add_increment_decode.sv
`timescale 1ns/1ns
`default_nettype none
module test_carry_add_increment_decode;
   import cadec_pkg::*;
   logic       sys_clk;
   logic       arst_n;
   logic       slow;
   logic       byte_valid;
   logic [7:0] byte_data;
   logic       byte_ready;
   logic       op_valid;
   logic       bad_opcode;
   cadec_op_t  op;
   int         fail_count;
   int         compares;

   cadec_decode uut (
      .sys_clk(sys_clk), .arst_n(arst_n), .byte_valid(byte_valid), .byte_data(byte_data),
      .byte_ready(byte_ready), .op_valid(op_valid), .op(op), .bad_opcode(bad_opcode)
   );
   cadec_fetch_model fetch (
      .sys_clk(sys_clk), .arst_n(arst_n), .byte_ready(byte_ready), .slow(slow),
      .byte_valid(byte_valid), .byte_data(byte_data)
   );

   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic wait_result(output logic ok);
      int n;
      n = 0;
      @(posedge sys_clk);
      #1;
      while (op_valid !== 1'b1 && bad_opcode !== 1'b1 && n < 60) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      ok = (op_valid === 1'b1);
   endtask : wait_result

   // execution hold is judged by counting cycles with byte_ready low
   task automatic expect_op(input cadec_kind_t k, input logic [3:0] clk_n, input logic [1:0] dc,
                            input logic mem, input logic [1:0] wd, input logic [31:0] dsp,
                            input logic [31:0] imv);
      logic ok;
      int   low;
      low = 0;
      wait_result(ok);
      check(ok, 1'b1);
      check(op.kind, k);
      check(op.clocks, clk_n);
      check(op.data_cycles, dc);
      check(op.is_mem, mem);
      check({op.wide, op.dir}, wd);
      if (mem) check(op.disp, dsp);
      if (k == CADEC_K_ADC_IMM || k == CADEC_K_ADC_ACC) check(op.imm, imv);
      while (byte_ready === 1'b0 && low < 20) begin
         low++;
         @(posedge sys_clk);
         #1;
      end
      check(low, clk_n);
   endtask : expect_op

   task automatic expect_bad();
      logic ok;
      wait_result(ok);
      check({ok, bad_opcode}, 2'b01);
   endtask : expect_bad

   task automatic sc_reg_reg();
      slow = 1'b0;
      fetch.push(64'h0000_0000_0000_C113, 2);
      expect_op(CADEC_K_ADC_RR, CLK_RR, DC_ZERO, 1'b0, 2'b11, '0, '0);
      fetch.push(64'h0000_0000_C010_C211, 4);
      expect_op(CADEC_K_ADC_RR, CLK_RR, DC_ZERO, 1'b0, 2'b10, '0, '0);
      expect_op(CADEC_K_ADC_RR, CLK_RR, DC_ZERO, 1'b0, 2'b00, '0, '0);
   endtask : sc_reg_reg

   task automatic sc_mem_forms();
      slow = 1'b1;
      fetch.push(64'h0000_0000_0080_4510, 3);
      expect_op(CADEC_K_ADC_RM, 4'h7, DC_TWO, 1'b1, 2'b00, 32'hFFFF_FF80, '0);
      fetch.push(64'h0000_1234_5678_0513, 6);
      expect_op(CADEC_K_ADC_MR, 4'h6, DC_ONE, 1'b1, 2'b11, 32'h1234_5678, '0);
      fetch.push(64'h0000_0403_0201_8811, 6);
      expect_op(CADEC_K_ADC_RM, 4'h7, DC_TWO, 1'b1, 2'b10, 32'h0403_0201, '0);
   endtask : sc_mem_forms

   task automatic sc_imm();
      slow = 1'b0;
      fetch.push(64'h0000_DDCC_BBAA_D081, 6);
      expect_op(CADEC_K_ADC_IMM, 4'h2, DC_ZERO, 1'b0, 2'b10, '0, 32'hDDCC_BBAA);
      slow = 1'b1;
      fetch.push(64'h0000_00FF_1024_5483, 5);
      expect_op(CADEC_K_ADC_IMM, 4'h7, DC_TWO, 1'b1, 2'b10, 32'h0000_0010, 32'hFFFF_FFFF);
      fetch.push(64'h0000_0000_0000_D880, 2);
      expect_bad();
   endtask : sc_imm

   task automatic sc_acc();
      slow = 1'b0;
      fetch.push(64'h0000_0044_3322_1115, 5);
      expect_op(CADEC_K_ADC_ACC, 4'h2, DC_ZERO, 1'b0, 2'b10, '0, 32'h4433_2211);
      fetch.push(64'h0000_0000_0000_9C14, 2);
      expect_op(CADEC_K_ADC_ACC, 4'h2, DC_ZERO, 1'b0, 2'b00, '0, 32'h0000_009C);
      fetch.push(64'h0000_0000_0000_0016, 1);
      expect_bad();
   endtask : sc_acc

   task automatic sc_inc();
      slow = 1'b1;
      fetch.push(64'h0000_0000_0000_C3FE, 2);
      expect_op(CADEC_K_INC, 4'h2, DC_ZERO, 1'b0, 2'b00, '0, '0);
      fetch.push(64'h0000_0000_0000_00FF, 2);
      expect_op(CADEC_K_INC, 4'h6, DC_TWO, 1'b1, 2'b10, 32'h0000_0000, '0);
      fetch.push(64'h0044_3322_1105_04FF, 7);
      expect_op(CADEC_K_INC, 4'h6, DC_TWO, 1'b1, 2'b10, 32'h4433_2211, '0);
      fetch.push(64'h0000_0000_0000_08FF, 2);
      expect_bad();
   endtask : sc_inc

   // a hang anywhere ends the run through the same verdict path
   initial begin
      #(5000 * 4);
      fail_count++;
      report_and_stop();
   end

   initial begin
      fail_count = 0;
      compares   = 0;
      slow       = 1'b0;
      arst_n     = 1'b0;
      repeat (12) @(negedge sys_clk);
      arst_n = 1'b1;
      sc_reg_reg();
      sc_mem_forms();
      sc_imm();
      sc_acc();
      sc_inc();
      report_and_stop();
   end
endmodule : test_carry_add_increment_decode
`default_nettype wire
